/* common/adcenc_pkg.sv */
// Shared constants for the encode clock link and output coding
package adcenc_pkg;
    // ------------------------------------------------------------
    // Data word and coding
    // ------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int AIN_W = 14;
    localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;
    localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
    localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
    localparam logic signed [AIN_W-1:0] AIN_POS_FS = 14'sh07ff;
    localparam logic signed [AIN_W-1:0] AIN_NEG_FS = -14'sh0800;
    localparam real LSB_VOLTS = 0.000488;
    localparam int PIPE_STAGES = 5;

    // ------------------------------------------------------------
    // Four-level strap (0, 1/3, 2/3, full supply)
    // ------------------------------------------------------------
    typedef logic [1:0] adcenc_strap_t;
    localparam adcenc_strap_t STRAP_GND = 2'h0;
    localparam adcenc_strap_t STRAP_THIRD = 2'h1;
    localparam adcenc_strap_t STRAP_TWO_THIRDS = 2'h2;
    localparam adcenc_strap_t STRAP_VDD = 2'h3;

    // ------------------------------------------------------------
    // Encode clock limits and timing
    // ------------------------------------------------------------
    localparam real MCLK_NS = 10.0;
    localparam real MAX_RATE_MSPS = 250.0;
    localparam real MIN_RATE_MSPS = 1.0;
    localparam real MIN_HALF_NS = 1.9;
    localparam int MIN_HALF_CYC = (int'($ceil(MIN_HALF_NS / MCLK_NS)) < 1) ? 1 : int'($ceil(MIN_HALF_NS / MCLK_NS));
    localparam int MIN_PERIOD_CYC = int'($ceil(1000.0 / (MAX_RATE_MSPS * MCLK_NS))) < 2 * MIN_HALF_CYC ?
        2 * MIN_HALF_CYC : int'($ceil(1000.0 / (MAX_RATE_MSPS * MCLK_NS)));
    localparam int MAX_PERIOD_CYC = int'($floor(1000.0 / (MIN_RATE_MSPS * MCLK_NS)));
    localparam int LOCK_EDGES = 100;
    localparam int STOP_CYC = 2 * MAX_PERIOD_CYC;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // Controller register map (APB, byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_HALF = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_DATA = 8'h10;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STRAP_LO = 1;
    localparam int ST_WORD = 0;
    localparam int ST_OVER = 1;
    localparam int EVT_W = 2;
    localparam logic [7:0] HALF_HI_RST = 8'h04;
    localparam logic [7:0] HALF_LO_RST = 8'h04;
endpackage

/* common/adcenc_link_if.sv */
// Pins between the converter digital side and its clock source / receiver
`timescale 1ns/1ns
interface adcenc_link_if;
    import adcenc_pkg::*;
    logic encode_in_pos;
    logic encode_in_neg;
    adcenc_strap_t format_strap;
    logic [CODE_W-1:0] sample_code_bits;
    logic overrange_flag;
    logic bus_a_data_strobe;

    modport device (
        input encode_in_pos,
        input encode_in_neg,
        input format_strap,
        output sample_code_bits,
        output overrange_flag,
        output bus_a_data_strobe
    );
    modport source (
        output encode_in_pos,
        output encode_in_neg,
        output format_strap,
        input sample_code_bits,
        input overrange_flag,
        input bus_a_data_strobe
    );
endinterface

/* src/adcenc_device.sv */
// Converter digital side: encode edge handling, stabilizer, pipeline and output coding
`timescale 1ns/1ns
module adcenc_device
    import adcenc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link pins
    adcenc_link_if.device link,
    // Analog side, signed in LSB units
    input wire logic signed [adcenc_pkg::AIN_W-1:0] ain_level,
    // Status
    output logic dcs_active,
    output logic dcs_locked,
    output logic twos_format
);
    import adcenc_pkg::*;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_HIGH = 3'b010,
        PH_LOW = 3'b100
    } adcenc_phase_e;

    function automatic logic strap_dcs(input adcenc_strap_t s);
        strap_dcs = (s == STRAP_THIRD) || (s == STRAP_TWO_THIRDS);
    endfunction

    function automatic logic strap_twos(input adcenc_strap_t s);
        strap_twos = (s == STRAP_TWO_THIRDS) || (s == STRAP_VDD);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic pos_s1_r, pos_s2_r, neg_s1_r, neg_s2_r;
    adcenc_strap_t strap_s1_r, strap_s2_r;
    logic enc_prev_r;
    logic enc_high, enc_rise, enc_fall;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pos_s1_r <= 1'b0;
            pos_s2_r <= 1'b0;
            neg_s1_r <= 1'b1;
            neg_s2_r <= 1'b1;
            strap_s1_r <= STRAP_GND;
            strap_s2_r <= STRAP_GND;
            enc_prev_r <= 1'b0;
        end else begin
            pos_s1_r <= link.encode_in_pos;
            pos_s2_r <= pos_s1_r;
            neg_s1_r <= link.encode_in_neg;
            neg_s2_r <= neg_s1_r;
            strap_s1_r <= link.format_strap;
            strap_s2_r <= strap_s1_r;
            enc_prev_r <= enc_high;
        end
    end

    // Differential decision: positive above negative means high
    assign enc_high = pos_s2_r & ~neg_s2_r;
    assign enc_rise = enc_high & ~enc_prev_r;
    assign enc_fall = ~enc_high & enc_prev_r;

    // ------------------------------------------------------------
    // Stabilizer: period measure, lock count, internal falling edge
    // ------------------------------------------------------------
    logic [CNT_W-1:0] since_rise_r, since_rise_nxt;
    logic [CNT_W-1:0] period_r, period_nxt;
    logic [6:0] lock_cnt_r, lock_cnt_nxt;
    logic locked_r, locked_nxt;
    logic dcs_on, twos_on, int_fall;

    assign dcs_on = strap_dcs(strap_s2_r);
    assign twos_on = strap_twos(strap_s2_r);
    // Half the measured period regardless of external duty
    assign int_fall = locked_r && (since_rise_r == (period_r >> 1));

    always_comb begin
        since_rise_nxt = since_rise_r;
        period_nxt = period_r;
        lock_cnt_nxt = lock_cnt_r;
        locked_nxt = locked_r;
        if (enc_rise) begin
            since_rise_nxt = CNT_W'(1);
            period_nxt = since_rise_r;
            if (lock_cnt_r != 7'(LOCK_EDGES))
                lock_cnt_nxt = lock_cnt_r + 7'h01;
            if (lock_cnt_r == 7'(LOCK_EDGES - 1))
                locked_nxt = 1'b1;
        end else if (since_rise_r != CNT_W'(STOP_CYC)) begin
            since_rise_nxt = since_rise_r + CNT_W'(1);
        end else begin
            // Clock stopped: the loop must reacquire
            lock_cnt_nxt = 7'h00;
            locked_nxt = 1'b0;
        end
        if (!dcs_on) begin
            lock_cnt_nxt = 7'h00;
            locked_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            since_rise_r <= '0;
            period_r <= '0;
            lock_cnt_r <= 7'h00;
            locked_r <= 1'b0;
        end else begin
            since_rise_r <= since_rise_nxt;
            period_r <= period_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            locked_r <= locked_nxt;
        end
    end

    // ------------------------------------------------------------
    // Conversion and pipeline
    // ------------------------------------------------------------
    logic [CODE_W:0] pipe_r [PIPE_STAGES];
    logic [CODE_W:0] pipe_nxt [PIPE_STAGES];
    logic [CODE_W:0] conv_word;
    logic timing_ok;

    // Without stabilizer the external edges are trusted directly
    assign timing_ok = !dcs_on || locked_r;

    always_comb begin
        logic [CODE_W-1:0] ob;
        logic over;
        ob = CODE_MID;
        over = 1'b0;
        if (ain_level > AIN_POS_FS) begin
            ob = CODE_MAX;
            over = 1'b1;
        end else if (ain_level < AIN_NEG_FS) begin
            ob = CODE_MIN;
            over = 1'b1;
        end else begin
            ob = CODE_W'(ain_level + 14'sh0800);
        end
        if (twos_on)
            ob[CODE_W-1] = ~ob[CODE_W-1];
        conv_word = {over, ob};
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIPE_STAGES; gi++) begin : g_pipe
            // Head stage split off so no stage ever names an index below zero
            if (gi == 0) begin : g_head
                always_comb begin
                    pipe_nxt[gi] = enc_rise ? conv_word : pipe_r[gi];
                end
            end else begin : g_tail
                always_comb begin
                    pipe_nxt[gi] = enc_rise ? pipe_r[gi-1] : pipe_r[gi];
                end
            end
            always_ff @(posedge mclk) begin
                if (sys_rst)
                    pipe_r[gi] <= {1'b0, CODE_MID};
                else
                    pipe_r[gi] <= pipe_nxt[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output bus and strobe
    // ------------------------------------------------------------
    adcenc_phase_e phase_r, phase_nxt;
    logic [CODE_W-1:0] code_r, code_nxt;
    logic of_r, of_nxt;
    logic strobe_r, strobe_nxt;

    always_comb begin
        phase_nxt = phase_r;
        code_r_hold: begin
            code_nxt = code_r;
            of_nxt = of_r;
        end
        strobe_nxt = strobe_r;
        case (phase_r)
            PH_IDLE: begin
                if (enc_rise && timing_ok) begin
                    // Word leaves the last stage as the next sample enters
                    code_nxt = pipe_r[PIPE_STAGES-1][CODE_W-1:0];
                    of_nxt = pipe_r[PIPE_STAGES-1][CODE_W];
                    phase_nxt = PH_HIGH;
                end
            end
            PH_HIGH: begin
                // Strobe rises one cycle after the word settles
                strobe_nxt = 1'b1;
                phase_nxt = PH_LOW;
            end
            PH_LOW: begin
                if (dcs_on ? int_fall : enc_fall) begin
                    strobe_nxt = 1'b0;
                    phase_nxt = PH_IDLE;
                end else if (enc_rise || !timing_ok) begin
                    // Very short high phase: close strobe before next word
                    strobe_nxt = 1'b0;
                    phase_nxt = PH_IDLE;
                end
            end
            default: begin
                strobe_nxt = 1'b0;
                phase_nxt = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_r <= PH_IDLE;
            code_r <= CODE_MID;
            of_r <= 1'b0;
            strobe_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            code_r <= code_nxt;
            of_r <= of_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    assign link.sample_code_bits = code_r;
    assign link.overrange_flag = of_r;
    assign link.bus_a_data_strobe = strobe_r;
    assign dcs_active = dcs_on;
    assign dcs_locked = locked_r;
    assign twos_format = twos_on;
endmodule

/* src/adcenc_source.sv */
// Encode clock source and data receiver with an APB register port
`timescale 1ns/1ns
module adcenc_source
    import adcenc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link pins
    adcenc_link_if.source link
);
    import adcenc_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic run_r, run_nxt;
    adcenc_strap_t strap_r, strap_nxt;
    logic [7:0] half_hi_r, half_hi_nxt, half_lo_r, half_lo_nxt;
    logic [EVT_W-1:0] status_r, status_nxt, mask_r, mask_nxt;
    logic [CODE_W:0] data_r, data_nxt;
    logic wr, rd_hit;
    logic [EVT_W-1:0] evt;

    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign rd_hit = (paddr == REG_CTRL) || (paddr == REG_HALF) || (paddr == REG_STATUS) ||
        (paddr == REG_MASK) || (paddr == REG_DATA);
    assign pslverr = psel && penable && !rd_hit;

    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            REG_CTRL: prdata = {29'h0, strap_r, run_r};
            REG_HALF: prdata = {16'h0, half_lo_r, half_hi_r};
            REG_STATUS: prdata = {30'h0, status_r};
            REG_MASK: prdata = {30'h0, mask_r};
            REG_DATA: prdata = {19'h0, data_r};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Encode clock divider
    // ------------------------------------------------------------
    logic [7:0] hi_cyc, lo_cyc, div_cnt_r, div_cnt_nxt;
    logic enc_r, enc_nxt;

    always_comb begin
        logic [7:0] h;
        logic [7:0] l;
        h = (half_hi_r < 8'(MIN_HALF_CYC)) ? 8'(MIN_HALF_CYC) : half_hi_r;
        l = (half_lo_r < 8'(MIN_HALF_CYC)) ? 8'(MIN_HALF_CYC) : half_lo_r;
        // Stabilizer off: force an even split
        if (!((strap_r == STRAP_THIRD) || (strap_r == STRAP_TWO_THIRDS)))
            l = h;
        if ({1'b0, h} + {1'b0, l} > 9'(MAX_PERIOD_CYC)) begin
            h = 8'(MAX_PERIOD_CYC / 2);
            l = 8'(MAX_PERIOD_CYC / 2);
        end
        if ({1'b0, h} + {1'b0, l} < 9'(MIN_PERIOD_CYC))
            h = 8'(MIN_PERIOD_CYC) - l;
        hi_cyc = h;
        lo_cyc = l;
    end

    always_comb begin
        enc_nxt = enc_r;
        div_cnt_nxt = div_cnt_r + 8'h01;
        if (!run_r) begin
            enc_nxt = 1'b0;
            div_cnt_nxt = 8'h00;
        end else if (enc_r ? (div_cnt_r >= hi_cyc - 8'h01) : (div_cnt_r >= lo_cyc - 8'h01)) begin
            enc_nxt = ~enc_r;
            div_cnt_nxt = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Receiver: capture on strobe falling edge
    // ------------------------------------------------------------
    logic stb_s1_r, stb_s2_r, stb_prev_r;
    logic [CODE_W:0] dat_s1_r, dat_s2_r;
    logic stb_fall;

    assign stb_fall = stb_prev_r && !stb_s2_r;
    assign evt[ST_WORD] = stb_fall;
    assign evt[ST_OVER] = stb_fall && dat_s2_r[CODE_W];

    always_comb begin
        run_nxt = run_r;
        strap_nxt = strap_r;
        half_hi_nxt = half_hi_r;
        half_lo_nxt = half_lo_r;
        mask_nxt = mask_r;
        data_nxt = stb_fall ? dat_s2_r : data_r;
        // Write-one-to-clear; a new event wins over the clear
        status_nxt = status_r;
        if (wr && paddr == REG_STATUS)
            status_nxt = status_r & ~pwdata[EVT_W-1:0];
        status_nxt = status_nxt | evt;
        if (wr) begin
            case (paddr)
                REG_CTRL: begin
                    run_nxt = pwdata[CTRL_RUN];
                    strap_nxt = pwdata[CTRL_STRAP_LO +: 2];
                end
                REG_HALF: begin
                    half_hi_nxt = pwdata[7:0];
                    half_lo_nxt = pwdata[15:8];
                end
                REG_MASK: mask_nxt = pwdata[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_r <= 1'b0;
            strap_r <= STRAP_GND;
            half_hi_r <= HALF_HI_RST;
            half_lo_r <= HALF_LO_RST;
            status_r <= '0;
            mask_r <= '0;
            data_r <= '0;
            enc_r <= 1'b0;
            div_cnt_r <= 8'h00;
            stb_s1_r <= 1'b0;
            stb_s2_r <= 1'b0;
            stb_prev_r <= 1'b0;
            dat_s1_r <= '0;
            dat_s2_r <= '0;
        end else begin
            run_r <= run_nxt;
            strap_r <= strap_nxt;
            half_hi_r <= half_hi_nxt;
            half_lo_r <= half_lo_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            data_r <= data_nxt;
            enc_r <= enc_nxt;
            div_cnt_r <= div_cnt_nxt;
            stb_s1_r <= link.bus_a_data_strobe;
            stb_s2_r <= stb_s1_r;
            stb_prev_r <= stb_s2_r;
            dat_s1_r <= {link.overrange_flag, link.sample_code_bits};
            dat_s2_r <= dat_s1_r;
        end
    end

    assign irq = |(status_r & mask_r);
    assign link.encode_in_pos = enc_r;
    assign link.encode_in_neg = ~enc_r;
    assign link.format_strap = strap_r;
endmodule

/* test/adcenc_sva.sv */
// Concurrent checks on the converter link pins
`timescale 1ns/1ns
module adcenc_sva
    import adcenc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Link pins
    input wire logic encode_in_pos,
    input wire logic encode_in_neg,
    input wire adcenc_pkg::adcenc_strap_t format_strap,
    input wire logic [adcenc_pkg::CODE_W-1:0] sample_code_bits,
    input wire logic overrange_flag,
    input wire logic bus_a_data_strobe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence launch_s;
        $rose(bus_a_data_strobe);
    endsequence
    // Long enough that no detected rise can still be in flight
    sequence enc_stopped_s;
        !encode_in_pos [*8];
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_code_then_strobe: assert property ($changed(sample_code_bits) |=> $rose(bus_a_data_strobe))
        else $error("code changed without a strobe rise next cycle");
    chk_flag_then_strobe: assert property ($changed(overrange_flag) |=> $rose(bus_a_data_strobe))
        else $error("flag changed without a strobe rise next cycle");
    chk_data_hold_high: assert property (bus_a_data_strobe |-> $stable(sample_code_bits) && $stable(overrange_flag))
        else $error("data moved while strobe high");
    chk_flag_saturates: assert property (launch_s ##0 overrange_flag |->
        ((sample_code_bits ^ {format_strap[1], 11'h000}) inside {CODE_MAX, CODE_MIN}))
        else $error("overrange word not saturated in selected format");
    chk_launch_after_enc: assert property (launch_s |->
        (($past(encode_in_pos, 3) && !$past(encode_in_neg, 3)) || $past(encode_in_pos, 4) || $past(encode_in_pos, 5)))
        else $error("strobe rose without a recent encode rise");
    chk_strobe_min_high: assert property (launch_s |=> bus_a_data_strobe)
        else $error("strobe pulse shorter than two cycles");
    chk_strobe_low_idle: assert property (enc_stopped_s |-> !bus_a_data_strobe)
        else $error("strobe high with encode stopped");
    chk_no_launch_idle: assert property (enc_stopped_s |-> $stable(sample_code_bits))
        else $error("word launched with encode stopped");
endmodule

/* test/tb.sv */
// Self-checking bench: source and device joined over the link, driven through APB
`timescale 1ns/1ns
module tb
    import adcenc_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic signed [AIN_W-1:0] ain_level = '0;
    logic dcs_active;
    logic dcs_locked;
    logic twos_format;
    logic strobe_q = 1'b0;
    logic enc_q = 1'b0;
    int mismatches = 0;
    int checked = 0;
    // First level differs from the reset word, so early launches cannot match it
    int vals[7] = '{1, 0, -1, 2047, 3000, -2048, -3000};

    always #5 mclk = ~mclk;

    adcenc_link_if link_if();
    adcenc_source adcenc_source_inst (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .link(link_if));
    adcenc_device adcenc_device_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link_if), .ain_level(ain_level),
        .dcs_active(dcs_active), .dcs_locked(dcs_locked), .twos_format(twos_format));
    adcenc_sva adcenc_sva_inst (.mclk(mclk), .sys_rst(sys_rst), .encode_in_pos(link_if.encode_in_pos),
        .encode_in_neg(link_if.encode_in_neg), .format_strap(link_if.format_strap),
        .sample_code_bits(link_if.sample_code_bits), .overrange_flag(link_if.overrange_flag),
        .bus_a_data_strobe(link_if.bus_a_data_strobe));

    // Previous samples for edge finding
    always @(posedge mclk) begin
        strobe_q <= link_if.bus_a_data_strobe;
        enc_q <= link_if.encode_in_pos;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic fail_wait(input string what);
        mismatches++;
        $display("[FAIL] %s expected event seen timeout", what);
        summarize();
    endtask

    // ------------------------------------------------------------
    // APB master: setup, access until pready, then one idle edge
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (n > 50) fail_wait("pready");
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, wd, rd, err);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0, rd, err);
        check(what, rd, exp);
    endtask

    // 0 strobe rise, 1 encode rise, 2 strobe fall
    task automatic wait_edge(input int which);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
            if (n > 600) fail_wait("link edge");
        end while (!((which == 0 && link_if.bus_a_data_strobe && !strobe_q) ||
                     (which == 1 && link_if.encode_in_pos && !enc_q) ||
                     (which == 2 && !link_if.bus_a_data_strobe && strobe_q)));
    endtask

    // One input level: latency, coding, capture, status and interrupt
    task automatic conv(input int v, input logic twos);
        logic [11:0] code;
        logic [12:0] exp;
        int k;
        int hit;
        code = (v > 2047) ? CODE_MAX : (v < -2048) ? CODE_MIN : 12'(v + 2048);
        code[11] = code[11] ^ twos;
        exp = {(v > 2047 || v < -2048), code};
        wait_edge(1);
        ain_level <= AIN_W'(v);
        hit = 0;
        for (k = 1; k <= 8 && hit == 0; k++) begin
            wait_edge(0);
            if ({link_if.overrange_flag, link_if.sample_code_bits} === exp) hit = k;
        end
        // Launch at the same rise still carries a word five rises older
        check("latency in strobes", hit, 6);
        check("flag and code", {link_if.overrange_flag, link_if.sample_code_bits}, exp);
        wait_edge(2);
        repeat (6) @(posedge mclk);
        rd_chk("captured word", REG_DATA, {19'h0, exp});
        wr(REG_STATUS, 32'h3);
        wait_edge(2);
        repeat (6) @(posedge mclk);
        rd_chk("status", REG_STATUS, {30'h0, exp[12], 1'b1});
        check("irq", irq, exp[12]);
    endtask

    task automatic measure(output int len);
        wait_edge(0);
        len = 0;
        while (link_if.bus_a_data_strobe === 1'b1 && len < 100) begin
            @(posedge mclk);
            len++;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic err;
        int n;
        int len1;
        int len2;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check("reset word", {link_if.overrange_flag, link_if.sample_code_bits}, {1'b0, CODE_MID});
        check("reset strobe", link_if.bus_a_data_strobe, 1'b0);
        check("reset lock", dcs_locked, 1'b0);
        rd_chk("half reset", REG_HALF, {16'h0, HALF_LO_RST, HALF_HI_RST});
        rd_chk("status reset", REG_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        check("unmapped error", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        wr(REG_MASK, 32'h2);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            wr(REG_CTRL, 32'(s * 2 + 1));
            // Strap still crossing the device's two-stage synchroniser
            repeat (3) @(posedge mclk);
            check("stabilizer on", dcs_active, (s == 1 || s == 2));
            check("twos format", twos_format, (s >= 2));
            if (s == 1 || s == 2) begin
                n = 0;
                while (dcs_locked !== 1'b1 && n < 200) begin
                    wait_edge(1);
                    n++;
                end
                check("rises to lock", (n >= 100 && n <= 104), 1'b1);
            end
            foreach (vals[i]) conv(vals[i], s >= 2);
            if (s == 1) begin
                wr(REG_HALF, 32'h0604);
                repeat (4) wait_edge(1);
                measure(len1);
                wr(REG_HALF, 32'h0406);
                repeat (4) wait_edge(1);
                measure(len2);
                // Internal fall comes from the loop, so external duty must not matter
                check("internal high time", len2, len1);
                wr(REG_HALF, 32'h0404);
            end
            wr(REG_CTRL, 32'(s * 2));
            repeat (250) @(posedge mclk);
            check("lock after stop", dcs_locked, 1'b0);
            $display("test strap %0d done", s);
        end
        wr(REG_MASK, 32'h0);
        check("irq masked", irq, 1'b0);
        wr(REG_MASK, 32'h2);
        check("irq unmasked", irq, 1'b1);
        wr(REG_STATUS, 32'h2);
        check("irq cleared", irq, 1'b0);
        $display("test interrupt done");
        summarize();
    end
endmodule
